// ==== fts_pkg.sv ====
// constants, types and register map of the frontend timer unit
package fts_pkg;

	// ----------------------------------------------------------------
	// clock rates in kHz
	// ----------------------------------------------------------------
	localparam int unsigned CLK_KHZ  = 125000; // system clock
	localparam int unsigned HF_KHZ   = 13560;  // fast counting clock
	localparam int unsigned SLOW_DIV = 64;     // fast ticks per slow tick

	// ----------------------------------------------------------------
	// counts and widths
	// ----------------------------------------------------------------
	localparam int unsigned NTMR   = 5;  // four general timers plus wake timer
	localparam int unsigned WAKE   = 4;  // index of the wake-up timer
	localparam int unsigned NEVT   = 3;  // external event inputs
	localparam int unsigned ACC_W  = 18; // fractional tick accumulator

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL   = 8'h00; // shared_timer_control
	localparam logic [7:0] A_SECOND_IRQ_STATUS   = 8'h04; // second_irq_status
	localparam logic [7:0] A_IRQ1EN = 8'h08; // second irq enable
	localparam logic [2:0] TMR_BANK = 3'h1;  // first timer bank at 0x20
	localparam logic [4:0] S_CTL    = 5'h00; // per-timer control
	localparam logic [4:0] S_MODE   = 5'h04; // per-timer mode
	localparam logic [4:0] S_RLD_HI = 5'h08; // reload_high_byte
	localparam logic [4:0] S_RLD_LO = 5'h0c; // reload_low_byte
	localparam logic [4:0] S_CNT_HI = 5'h10; // count_high_byte
	localparam logic [4:0] S_CNT_LO = 5'h14; // count_low_byte

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTL_CLK   = 0; // [1:0] clock select
	localparam int CTL_AR    = 2; // auto_reload_option
	localparam int CTL_AW    = 3; // auto_wakeup_option (wake timer)
	localparam int CTL_START = 4; // [5:4] start event select
	localparam int CTL_STOP  = 6; // [7:6] stop event select
	localparam int MODE_GO   = 0; // start pulse
	localparam int MODE_HALT = 1; // stop pulse
	localparam int MODE_STBY = 2; // enter standby (wake timer)
	localparam int IRQ_ANY   = 6; // any_irq_flag
	localparam int IRQ_SET   = 7; // set (1) or clear (0) selector
	localparam int CTRL_ACT  = 4; // immediate_action_bit field

	// clock select codes and the no-event select code
	localparam logic [1:0] CLK_HF   = 2'h0;
	localparam logic [1:0] CLK_SLOW = 2'h1;
	localparam logic [1:0] CLK_WAKE = 2'h2;
	localparam logic [1:0] EVT_NONE = 2'h0; // immediate start / no stop

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {TS_IDLE, TS_ARMED, TS_COUNT} fts_tstate_t;

	typedef struct packed {
		logic        hsel;
		logic [7:0]  haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} fts_ahb_req_t;

	typedef struct packed {
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
	} fts_ahb_rsp_t;

	typedef struct packed {
		logic [ACC_W-1:0]       acc;
		logic [5:0]             div;
		logic                   osc_q;
		logic [NTMR-1:0][15:0]  cnt;
		logic [NTMR-1:0][15:0]  rld;
		logic [NTMR-1:0][7:0]   ctl;
		fts_tstate_t [NTMR-1:0] st;
		logic [NTMR-1:0]        flag;
		logic [NTMR-1:0]        irq_en;
		logic                   standby;
		logic                   wr_pend;
		logic                   rd_wait;
		logic [7:0]             addr;
		logic [7:0]             rdata;
	} fts_state_t;

endpackage

// ==== fts_timer_unit.sv ====
// frontend timer unit: four counting timers, a wake timer, ahb-lite regs
`timescale 1ns/10ps

module fts_timer_unit #(
	parameter int unsigned CLK_KHZ  = fts_pkg::CLK_KHZ,
	parameter int unsigned HF_KHZ   = fts_pkg::HF_KHZ,
	parameter int unsigned SLOW_DIV = fts_pkg::SLOW_DIV
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire fts_pkg::fts_ahb_req_t ahb_i,
	output fts_pkg::fts_ahb_rsp_t      ahb_o,
	input  wire logic [2:0]            event_i,
	input  wire logic                  low_freq_osc_i,
	input  wire logic                  detect_done_i,
	input  wire logic                  card_found_i,
	output logic                       irq_o,
	output logic                       standby_o,
	output logic [3:0]                 running_o
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (HF_KHZ == 0 || HF_KHZ >= CLK_KHZ || CLK_KHZ >= (1 << fts_pkg::ACC_W))
		$error("fts_timer_unit: clock rates out of range");
	if (SLOW_DIV < 2 || SLOW_DIV > 64)
		$error("fts_timer_unit: SLOW_DIV must be 2..64");

	localparam logic [fts_pkg::ACC_W-1:0] INC  = fts_pkg::ACC_W'(HF_KHZ);
	localparam logic [fts_pkg::ACC_W-1:0] WRAP = fts_pkg::ACC_W'(CLK_KHZ);
	localparam logic [5:0] DIV_LAST = 6'(SLOW_DIV - 1);

	// ----------------------------------------------------------------
	// address decode shared by read and write paths
	// ----------------------------------------------------------------
	// returns {hit, index}; timer banks are 32 bytes apart
	function automatic logic [3:0] tmr_dec(input logic [7:0] a);
		logic [2:0] bank;
		bank = a[7:5] - fts_pkg::TMR_BANK;
		tmr_dec = {(a[7:5] >= fts_pkg::TMR_BANK) &&
			(bank < 3'(fts_pkg::NTMR)), bank};
	endfunction

	// level of the event input chosen by a non-zero select code, 0 for code 0
	function automatic logic evt_pick(input logic [2:0] ev,
		input logic [1:0] sel);
		evt_pick = (sel != fts_pkg::EVT_NONE) && ev[sel - 2'h1];
	endfunction

	fts_pkg::fts_state_t s_q;
	fts_pkg::fts_state_t s_d;

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [fts_pkg::ACC_W-1:0] sum;
		logic                      hf_tick;
		logic                      slow_tick;
		logic                      osc_tick;
		logic [3:0]                dec;
		logic [7:0]                wdat;
		logic [fts_pkg::NTMR-1:0]  go;
		logic [fts_pkg::NTMR-1:0]  halt;
		logic [fts_pkg::NTMR-1:0]  f_set;
		logic [fts_pkg::NTMR-1:0]  f_clr;
		logic [fts_pkg::NTMR-1:0]  uf;
		logic                      tick;
		logic                      sev;
		logic                      stp;
		logic [1:0]                csel;
		sum       = '0;
		hf_tick   = 1'b0;
		slow_tick = 1'b0;
		osc_tick  = 1'b0;
		dec       = '0;
		wdat      = '0;
		go        = '0;
		halt      = '0;
		f_set     = '0;
		f_clr     = '0;
		uf        = '0;
		tick      = 1'b0;
		sev       = 1'b0;
		stp       = 1'b0;
		csel      = '0;
		s_d       = s_q;

		// fractional divider gives the fast tick on average rate
		sum = s_q.acc + INC;
		if (sum >= WRAP)
		begin
			s_d.acc = sum - WRAP;
			hf_tick = 1'b1;
		end
		else
			s_d.acc = sum;

		// slow tick: one pulse per SLOW_DIV fast ticks
		if (hf_tick)
		begin
			slow_tick = (s_q.div == DIV_LAST);
			s_d.div   = slow_tick ? 6'h00 : s_q.div + 6'h01;
		end

		// oscillator rising edge clocks the wake timer
		osc_tick  = low_freq_osc_i & ~s_q.osc_q;
		s_d.osc_q = low_freq_osc_i;

		// bus write data phase
		wdat = ahb_i.hwdata[7:0];
		dec  = tmr_dec(s_q.addr);
		if (s_q.wr_pend)
		begin
			if (s_q.addr == fts_pkg::A_CTRL)
			begin
				// action bit picks timers, running bit says start or stop
				for (int i = 0; i < 4; i++)
				begin
					if (wdat[fts_pkg::CTRL_ACT + i])
					begin
						go[i]   = wdat[i];
						halt[i] = ~wdat[i];
					end
				end
			end
			else if (s_q.addr == fts_pkg::A_SECOND_IRQ_STATUS)
			begin
				// top bit chooses set or clear of the marked flags
				if (wdat[fts_pkg::IRQ_SET])
					f_set = wdat[fts_pkg::NTMR-1:0];
				else
					f_clr = wdat[fts_pkg::NTMR-1:0];
			end
			else if (s_q.addr == fts_pkg::A_IRQ1EN)
				s_d.irq_en = wdat[fts_pkg::NTMR-1:0];
			else if (dec[3])
			begin
				unique case (s_q.addr[4:0])
					fts_pkg::S_CTL:    s_d.ctl[dec[2:0]] = wdat;
					fts_pkg::S_MODE:
					begin
						go[dec[2:0]]   = wdat[fts_pkg::MODE_GO];
						halt[dec[2:0]] = wdat[fts_pkg::MODE_HALT];
						if (dec[2:0] == 3'(fts_pkg::WAKE) &&
							wdat[fts_pkg::MODE_STBY])
							s_d.standby = 1'b1;
					end
					fts_pkg::S_RLD_HI: s_d.rld[dec[2:0]][15:8] = wdat;
					fts_pkg::S_RLD_LO: s_d.rld[dec[2:0]][7:0]  = wdat;
					default: ;
				endcase
			end
		end

		// timers, wake timer first so its underflow can clock the rest
		for (int i = fts_pkg::NTMR - 1; i >= 0; i--)
		begin
			csel = s_q.ctl[i][fts_pkg::CTL_CLK +: 2];
			if (i == fts_pkg::WAKE)
				tick = osc_tick;
			else
				unique case (csel)
					fts_pkg::CLK_HF:   tick = hf_tick;
					fts_pkg::CLK_SLOW: tick = slow_tick;
					fts_pkg::CLK_WAKE: tick = uf[fts_pkg::WAKE];
					default:           tick = 1'b0;
				endcase
			sev = (s_q.ctl[i][fts_pkg::CTL_START +: 2] == fts_pkg::EVT_NONE)
				|| evt_pick(event_i, s_q.ctl[i][fts_pkg::CTL_START +: 2]);
			stp = evt_pick(event_i, s_q.ctl[i][fts_pkg::CTL_STOP +: 2]);

			unique case (s_q.st[i])
				fts_pkg::TS_IDLE: ;
				fts_pkg::TS_ARMED:
				begin
					if (stp)
						s_d.st[i] = fts_pkg::TS_IDLE;
					else if (sev)
						s_d.st[i] = fts_pkg::TS_COUNT;
				end
				fts_pkg::TS_COUNT:
				begin
					if (stp)
						s_d.st[i] = fts_pkg::TS_IDLE;
					else if (tick)
					begin
						if (s_q.cnt[i] == 16'h0000)
						begin
							uf[i] = 1'b1;
							if (s_q.ctl[i][fts_pkg::CTL_AR])
								s_d.cnt[i] = s_q.rld[i];
							else
								s_d.st[i] = fts_pkg::TS_IDLE;
						end
						else
							s_d.cnt[i] = s_q.cnt[i] - 16'h0001;
					end
				end
			endcase

			// commands: stop wins over start in the same write
			if (halt[i])
				s_d.st[i] = fts_pkg::TS_IDLE;
			else if (go[i])
			begin
				s_d.cnt[i] = s_q.rld[i];
				s_d.st[i]  = fts_pkg::TS_ARMED;
			end
		end

		// hardware set wins over a host clear in the same cycle
		s_d.flag = (s_q.flag & ~f_clr) | f_set | uf;

		// wake timer expiry leaves standby; auto-wakeup re-enters it
		if (uf[fts_pkg::WAKE] && s_q.standby)
			s_d.standby = 1'b0;
		else if (!s_q.standby && s_q.ctl[fts_pkg::WAKE][fts_pkg::CTL_AW] &&
			detect_done_i && !card_found_i)
			s_d.standby = 1'b1;

		// read data phase: one wait state, data from flops
		s_d.rd_wait = 1'b0;
		if (s_q.rd_wait)
		begin
			s_d.rdata = 8'h00;
			if (s_q.addr == fts_pkg::A_CTRL)
				for (int i = 0; i < 4; i++)
					s_d.rdata[i] = (s_q.st[i] != fts_pkg::TS_IDLE);
			else if (s_q.addr == fts_pkg::A_SECOND_IRQ_STATUS)
			begin
				s_d.rdata[fts_pkg::NTMR-1:0] = s_q.flag;
				s_d.rdata[fts_pkg::IRQ_ANY]  = |(s_q.flag & s_q.irq_en);
			end
			else if (s_q.addr == fts_pkg::A_IRQ1EN)
				s_d.rdata[fts_pkg::NTMR-1:0] = s_q.irq_en;
			else if (dec[3])
				unique case (s_q.addr[4:0])
					fts_pkg::S_CTL:    s_d.rdata = s_q.ctl[dec[2:0]];
					fts_pkg::S_MODE:
					begin
						s_d.rdata[fts_pkg::MODE_GO] =
							(s_q.st[dec[2:0]] != fts_pkg::TS_IDLE);
						s_d.rdata[fts_pkg::MODE_STBY] = s_q.standby;
					end
					fts_pkg::S_RLD_HI: s_d.rdata = s_q.rld[dec[2:0]][15:8];
					fts_pkg::S_RLD_LO: s_d.rdata = s_q.rld[dec[2:0]][7:0];
					fts_pkg::S_CNT_HI: s_d.rdata = s_q.cnt[dec[2:0]][15:8];
					fts_pkg::S_CNT_LO: s_d.rdata = s_q.cnt[dec[2:0]][7:0];
					default: ;
				endcase
		end

		// address phase capture
		s_d.wr_pend = 1'b0;
		if (ahb_i.hready && ahb_i.hsel && ahb_i.htrans[1])
		begin
			s_d.addr    = ahb_i.haddr;
			s_d.wr_pend = ahb_i.hwrite;
			s_d.rd_wait = ~ahb_i.hwrite;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_q <= '0;
			for (int i = 0; i < fts_pkg::NTMR; i++)
				s_q.st[i] <= fts_pkg::TS_IDLE;
		end
		else
			s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign ahb_o.hreadyout = ~s_q.rd_wait;
	assign ahb_o.hresp     = 1'b0;
	assign ahb_o.hrdata    = {24'h000000, s_q.rdata};
	assign irq_o           = |(s_q.flag & s_q.irq_en);
	assign standby_o       = s_q.standby;

	// running status of timers 0..3
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			running_o[i] = (s_q.st[i] != fts_pkg::TS_IDLE);
	end

endmodule

// ==== fts_timer_monitor.sv ====
// port-level assertion checker for the frontend timer unit
`timescale 1ns/10ps

module fts_timer_monitor (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire fts_pkg::fts_ahb_req_t ahb_i,
	input  wire fts_pkg::fts_ahb_rsp_t ahb_o,
	input  wire logic [2:0]            event_i,
	input  wire logic                  low_freq_osc_i,
	input  wire logic                  detect_done_i,
	input  wire logic                  card_found_i,
	input  wire logic                  irq_o,
	input  wire logic                  standby_o,
	input  wire logic [3:0]            running_o
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// a transfer is taken in this address phase
	wire logic take = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	bus_okay_a: assert property (
		ahb_o.hresp == 1'b0)
		else $error("bus response not okay");
	wait_single_a: assert property (
		!ahb_o.hreadyout |=> ahb_o.hreadyout)
		else $error("read wait longer than one cycle");
	read_wait_a: assert property (
		take && !ahb_i.hwrite |=> !ahb_o.hreadyout ##1 ahb_o.hreadyout)
		else $error("read data phase not two cycles");
	write_nowait_a: assert property (
		take && ahb_i.hwrite |=> ahb_o.hreadyout)
		else $error("write got a wait state");
	rdata_upper_a: assert property (
		ahb_o.hrdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	rdata_hold_a: assert property (
		$past(ahb_o.hreadyout) && !$past(rst_i) |-> $stable(ahb_o.hrdata))
		else $error("read data changed outside a read");
	reset_clear_a: assert property (
		$fell(rst_i) |-> !irq_o && running_o == 4'h0 && !standby_o)
		else $error("outputs not cleared by reset");
	run_start_a: assert property (
		(running_o & ~$past(running_o)) != 4'h0 && !$past(rst_i)
		|-> $past(take && ahb_i.hwrite, 2))
		else $error("timer started without a write");
	standby_set_a: assert property (
		$rose(standby_o) && !$past(rst_i) |-> $past(take && ahb_i.hwrite, 2)
		|| ($past(detect_done_i) && !$past(card_found_i)))
		else $error("standby entered without cause");
	standby_wake_a: assert property (
		$fell(standby_o) && !$past(rst_i) |-> $past(low_freq_osc_i)
		|| $past(low_freq_osc_i, 2) || $past(low_freq_osc_i, 3))
		else $error("standby left without a wake tick");
endmodule

// ==== tb_top.sv ====
// self-checking bench for the frontend timer unit
`timescale 1ns/10ps

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
	err_count++; $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
	end end

module tb_top;
	logic                  clk_i;
	logic                  rst_i;
	fts_pkg::fts_ahb_req_t mreq;
	fts_pkg::fts_ahb_req_t bus;
	fts_pkg::fts_ahb_rsp_t rsp;
	logic [2:0]            event_i;
	logic                  osc;
	logic                  det;
	logic                  card;
	logic                  irq_o;
	logic                  standby_o;
	logic [3:0]            running_o;
	int                    err_count;
	int                    checked;

	// single slave: its hreadyout is the bus hready
	always_comb
	begin
		bus = mreq;
		bus.hready = rsp.hreadyout;
	end

	fts_timer_unit fts_timer_unit_inst (
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.ahb_i          (bus),
		.ahb_o          (rsp),
		.event_i        (event_i),
		.low_freq_osc_i (osc),
		.detect_done_i  (det),
		.card_found_i   (card),
		.irq_o          (irq_o),
		.standby_o      (standby_o),
		.running_o      (running_o)
	);

	// free-running system clock
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	function automatic logic [7:0] ta(input int x, input logic [4:0] s);
		return {fts_pkg::TMR_BANK + 3'(x), s};
	endfunction

	// one single word transfer, entered just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [31:0] q);
		mreq.hsel   <= 1'b1;
		mreq.htrans <= 2'h2;
		mreq.haddr  <= a;
		mreq.hwrite <= w;
		mreq.hsize  <= 3'h2;
		do @(posedge clk_i); while (rsp.hreadyout !== 1'b1);
		mreq.hsel   <= 1'b0;
		mreq.htrans <= 2'h0;
		mreq.hwdata <= {24'h0, d};
		do @(posedge clk_i); while (rsp.hreadyout !== 1'b1);
		q = rsp.hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 8'h00, q);
		`CHK(q, {24'h0, e})
	endtask

	// wake oscillator ticks, high and low three cycles each
	task automatic tick(input int n);
		repeat (n)
		begin
			osc <= 1'b1;
			repeat (3) @(posedge clk_i);
			osc <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
	endtask

	task automatic ev(input logic [2:0] v);
		event_i <= v;
		@(posedge clk_i);
		event_i <= 3'h0;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic detect(input logic c);
		card <= c;
		det  <= 1'b1;
		@(posedge clk_i);
		det <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	task automatic results;
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		mreq = '0;
		event_i = 3'h0;
		osc = 1'b0;
		det = 1'b0;
		card = 1'b0;
		err_count = 0;
		checked = 0;
		rst_i = 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rd(fts_pkg::A_CTRL, 8'h00);
		rd(fts_pkg::A_SECOND_IRQ_STATUS, 8'h00);
		rd(ta(4, fts_pkg::S_RLD_LO), 8'h00);
		rd(8'hfc, 8'h00);
		wr(ta(4, fts_pkg::S_RLD_HI), 8'hff);
		wr(ta(4, fts_pkg::S_RLD_LO), 8'hff);
		wr(ta(4, fts_pkg::S_MODE), 8'h01);
		rd(ta(4, fts_pkg::S_CNT_HI), 8'hff);
		rd(ta(4, fts_pkg::S_CNT_LO), 8'hff);
		wr(ta(4, fts_pkg::S_MODE), 8'h02);
		rd(ta(4, fts_pkg::S_MODE), 8'h00);
		$display("test registers done");
		wr(ta(4, fts_pkg::S_RLD_HI), 8'h00);
		wr(ta(4, fts_pkg::S_RLD_LO), 8'h03);
		wr(ta(4, fts_pkg::S_MODE), 8'h01);
		rd(ta(4, fts_pkg::S_MODE), 8'h01);
		tick(3);
		rd(ta(4, fts_pkg::S_CNT_LO), 8'h00);
		rd(fts_pkg::A_SECOND_IRQ_STATUS, 8'h00);
		tick(1);
		rd(fts_pkg::A_SECOND_IRQ_STATUS, 8'h10);
		rd(ta(4, fts_pkg::S_MODE), 8'h00);
		rd(ta(4, fts_pkg::S_CNT_LO), 8'h00);
		wr(fts_pkg::A_SECOND_IRQ_STATUS, 8'h10);
		rd(fts_pkg::A_SECOND_IRQ_STATUS, 8'h00);
		$display("test one shot done");
		wr(ta(4, fts_pkg::S_CTL), 8'h04);
		wr(ta(4, fts_pkg::S_RLD_LO), 8'h00);
		wr(ta(4, fts_pkg::S_MODE), 8'h01);
		wr(ta(0, fts_pkg::S_CTL), 8'h06);
		wr(ta(0, fts_pkg::S_RLD_LO), 8'h01);
		wr(fts_pkg::A_IRQ1EN, 8'h01);
		wr(fts_pkg::A_CTRL, 8'h11);
		@(posedge clk_i);
		`CHK(running_o, 4'h1)
		tick(2);
		`CHK(irq_o, 1'b1)
		rd(fts_pkg::A_SECOND_IRQ_STATUS, 8'h51);
		wr(fts_pkg::A_SECOND_IRQ_STATUS, 8'h11);
		tick(2);
		rd(fts_pkg::A_SECOND_IRQ_STATUS, 8'h51);
		wr(fts_pkg::A_CTRL, 8'h10);
		wr(fts_pkg::A_SECOND_IRQ_STATUS, 8'h1f);
		@(posedge clk_i);
		`CHK(running_o, 4'h0)
		`CHK(irq_o, 1'b0)
		$display("test periodic done");
		wr(ta(1, fts_pkg::S_CTL), 8'h62);
		wr(ta(1, fts_pkg::S_RLD_LO), 8'h05);
		wr(fts_pkg::A_CTRL, 8'h22);
		tick(2);
		rd(ta(1, fts_pkg::S_CNT_LO), 8'h05);
		ev(3'h2);
		tick(2);
		rd(ta(1, fts_pkg::S_CNT_LO), 8'h03);
		wr(fts_pkg::A_SECOND_IRQ_STATUS, 8'h1f);
		ev(3'h1);
		`CHK(running_o, 4'h0)
		tick(1);
		rd(ta(1, fts_pkg::S_CNT_LO), 8'h03);
		rd(fts_pkg::A_SECOND_IRQ_STATUS, 8'h10);
		$display("test events done");
		wr(fts_pkg::A_SECOND_IRQ_STATUS, 8'h1f);
		wr(fts_pkg::A_IRQ1EN, 8'h02);
		wr(fts_pkg::A_SECOND_IRQ_STATUS, 8'h82);
		rd(fts_pkg::A_SECOND_IRQ_STATUS, 8'h42);
		`CHK(irq_o, 1'b1)
		wr(fts_pkg::A_SECOND_IRQ_STATUS, 8'h02);
		@(posedge clk_i);
		`CHK(irq_o, 1'b0)
		$display("test host flags done");
		detect(1'b0);
		`CHK(standby_o, 1'b0)
		wr(ta(4, fts_pkg::S_CTL), 8'h0c);
		detect(1'b0);
		`CHK(standby_o, 1'b1)
		rd(ta(4, fts_pkg::S_MODE), 8'h05);
		tick(1);
		`CHK(standby_o, 1'b0)
		wr(ta(4, fts_pkg::S_MODE), 8'h04);
		@(posedge clk_i);
		`CHK(standby_o, 1'b1)
		tick(1);
		`CHK(standby_o, 1'b0)
		$display("test standby done");
		// timer 3 on the fast clock, timer 2 on the slow enable pulse
		wr(fts_pkg::A_SECOND_IRQ_STATUS, 8'h1f);
		wr(ta(3, fts_pkg::S_CTL), 8'h00);
		wr(ta(3, fts_pkg::S_RLD_LO), 8'h0a);
		wr(ta(2, fts_pkg::S_CTL), 8'h01);
		wr(ta(2, fts_pkg::S_RLD_LO), 8'h01);
		wr(fts_pkg::A_CTRL, 8'hcc);
		// eleven fast ticks take at least 90 cycles
		repeat (80) @(posedge clk_i);
		rd(fts_pkg::A_SECOND_IRQ_STATUS, 8'h00);
		// and at most 110 cycles
		repeat (60) @(posedge clk_i);
		rd(fts_pkg::A_SECOND_IRQ_STATUS, 8'h08);
		// two slow ticks need 576 to 1280 cycles
		repeat (350) @(posedge clk_i);
		rd(fts_pkg::A_SECOND_IRQ_STATUS, 8'h08);
		repeat (850) @(posedge clk_i);
		rd(fts_pkg::A_SECOND_IRQ_STATUS, 8'h0c);
		$display("test clock rates done");
		results();
	end

	// cut a hang short well beyond the expected run
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		results();
	end
endmodule

bind fts_timer_unit fts_timer_monitor fts_timer_monitor_inst (
	.clk_i          (clk_i),
	.rst_i          (rst_i),
	.ahb_i          (ahb_i),
	.ahb_o          (ahb_o),
	.event_i        (event_i),
	.low_freq_osc_i (low_freq_osc_i),
	.detect_done_i  (detect_done_i),
	.card_found_i   (card_found_i),
	.irq_o          (irq_o),
	.standby_o      (standby_o),
	.running_o      (running_o)
);
